// ==== core/darx_regs.sv ====
/*
 * Control and status register bank of the audio receiver.
 * Assumes the control port decoder runs on i_clk and hands over whole bytes.
 */
// Summary of operation
// - Pointer top bit enables auto-increment after each byte; low seven bits address.
// - With clock-switch set and lock lost, system clock drives recovered-clock pin.
// - Mute bit zeroes the serial output samples.
// - Interrupt pin style: active high, active low, open drain; code 11 reserved.
// - On receiver error: repeat last good sample, zero it, or pass it.
// - Ratio bit selects recovered clock of 256 or 128 times sample rate.
// - Mono mode duplicates each subframe to left and right at doubled rate.
// - Three-bit field selects one of seven receiver inputs; 111 reserved.
// - Run low holds link logic reset; registers stay accessible, buffers not.
// - Master bit makes the output port drive bit and word clocks.
// - In master mode bit clock is 64 or 128 times sample rate.
// - Word length code gives 24, 20 or 16 bits.
// - Word length code 11 outputs raw received data off the recovered clock.
// - Right justification is honoured only in master mode.
// - Delay bit places the MSB one bit clock later for left justification.
// - Polarity bits choose bit-clock sampling edge and word-clock channel sense.
// - Status bits are sticky, cleared on read unless a level source persists.
// - A status bit masked off always reads zero.
// - Output slip in slave mode sets the slip status bit.
// - Buffer transfer done and receiver error each set a status bit.
// - Two-bit mode per source: rising, falling or level trigger.
// - Mask bit one lets a source reach status and pin; masks reset zero.
`timescale 1ns/100ps
module darx_regs #(
   parameter int SW = darx_pkg::SAMPLE_W,
   parameter logic [7:0] ID_VAL = darx_pkg::ID_VERSION
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_link_clk,
   input wire logic i_map_wr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   input wire logic [7:0] i_rx_cs_data,
   input wire logic [7:0] i_clock_ratio,
   input wire logic [7:0] i_buf_rdata,
   input wire logic [6:0] i_rx_err,
   input wire logic [darx_pkg::NEVT-1:0] i_evt,
   input wire logic i_sub_valid,
   input wire logic i_sub_b,
   input wire logic i_sub_err,
   input wire logic [SW-1:0] i_sub_data,
   output logic o_irq_out,
   output logic o_irq_oe,
   output logic o_run,
   output logic o_clk_switch,
   output logic o_rclk_ratio_sel,
   output logic [2:0] o_input_select,
   output logic o_out_master,
   output logic o_bclk_rate_sel,
   output logic [1:0] o_word_len,
   output logic o_raw_mode,
   output logic o_justify_right,
   output logic o_msb_delay,
   output logic o_bclk_pol,
   output logic o_wclk_pol,
   output logic [SW-1:0] o_left,
   output logic [SW-1:0] o_right,
   output logic o_pair_valid
);
   import darx_pkg::*;
   // The identity value is arbitrary.
   logic [7:0] ptr;
   logic [7:0] gen;
   logic [7:0] rxc;
   logic [7:0] clks;
   logic [7:0] fmt;
   logic [7:0] msk1;
   logic [7:0] md1h;
   logic [7:0] md1l;
   logic [7:0] msk2;
   logic [7:0] md2h;
   logic [7:0] md2l;
   logic [7:0] emsk;
   logic [7:0] csb;
   logic [7:0] ub;
   logic [7:0] st1;
   logic [7:0] st2;
   logic [6:0] est;
   logic [6:0] err_s1;
   logic [6:0] err_s2;
   logic [NEVT-1:0] tg_s1;
   logic [NEVT-1:0] tg_s2;
   logic [NEVT-1:0] tg_s3;
   logic [NEVT-1:0] evt_p;
   logic [NEVT-1:0] evt_tgl;
   logic [7:0] cond1;
   logic [7:0] cond2;
   logic [7:0] cond1_q;
   logic [7:0] cond2_q;
   logic [7:0] trig1;
   logic [7:0] trig2;
   logic [7:0] next_rdata;
   logic [6:0] addr;
   logic rd_en;
   logic wr_en;
   logic irq_act;
   logic buf_hit;

   // Rising, falling or level trigger chosen per bit by the two mode registers.
   function automatic logic [7:0] darx_trig(input logic [7:0] c, input logic [7:0] cq,
                                            input logic [7:0] mh, input logic [7:0] ml);
      darx_trig = (~mh & ~ml & c & ~cq) | (~mh & ml & ~c & cq) | (mh & ~ml & c);
   endfunction : darx_trig

   assign addr = ptr[6:0];
   assign rd_en = i_rd && !i_map_wr;
   assign wr_en = i_wr && !i_map_wr && !i_rd;
   assign buf_hit = (addr >= ADDR_BUF_LO) && (addr <= ADDR_BUF_HI);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ptr <= RST_BYTE;
      end else if (i_map_wr) begin
         ptr <= i_wdata;
      end else if ((rd_en || wr_en) && ptr[BIT_POINTER_AUTOINC]) begin
         ptr[6:0] <= ptr[6:0] + ADDR_STEP;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gen <= RST_BYTE;
         rxc <= RST_BYTE;
         clks <= RST_BYTE;
         fmt <= RST_BYTE;
         msk1 <= RST_BYTE;
         md1h <= RST_BYTE;
         md1l <= RST_BYTE;
         msk2 <= RST_BYTE;
         md2h <= RST_BYTE;
         md2l <= RST_BYTE;
         emsk <= RST_BYTE;
         csb <= RST_BYTE;
         ub <= RST_BYTE;
      end else if (wr_en) begin
         case (addr)
            ADDR_CTRL_GEN: gen <= i_wdata & WM_GEN;
            ADDR_CTRL_RX: rxc <= i_wdata & WM_RX;
            ADDR_CLK_SRC: clks <= i_wdata & WM_CLK;
            ADDR_OUT_FMT: fmt <= i_wdata;
            ADDR_IMSK1: msk1 <= i_wdata & WM_INT1;
            ADDR_IMD1H: md1h <= i_wdata & WM_INT1;
            ADDR_IMD1L: md1l <= i_wdata & WM_INT1;
            ADDR_IMSK2: msk2 <= i_wdata & WM_INT2;
            ADDR_IMD2H: md2h <= i_wdata & WM_INT2;
            ADDR_IMD2L: md2l <= i_wdata & WM_INT2;
            ADDR_ERR_MSK: emsk <= i_wdata & WM_ERR;
            ADDR_CSB_CTL: csb <= i_wdata & WM_CSB;
            ADDR_UB_CTL: ub <= i_wdata & WM_UB;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         err_s1 <= '0;
         err_s2 <= '0;
         tg_s1 <= '0;
         tg_s2 <= '0;
         tg_s3 <= '0;
      end else begin
         err_s1 <= i_rx_err;
         err_s2 <= err_s1;
         tg_s1 <= evt_tgl;
         tg_s2 <= tg_s1;
         tg_s3 <= tg_s2;
      end
   end
   assign evt_p = tg_s2 ^ tg_s3;

   always_comb begin
      cond1 = RST_BYTE;
      cond2 = RST_BYTE;
      cond1[INT1_OUTPUT_SLIP_FLAG] = evt_p[EVT_SLIP] && !fmt[FMT_OUT_PORT_MASTER_SEL];
      cond1[INT1_STATUS_BUFFER_DONE_FLAG] = evt_p[EVT_STATUS_BUFFER_DONE_FLAG];
      cond1[INT1_RECEIVER_ERROR_FLAG] = |(err_s2 & emsk[6:0]);
      cond2[INT2_DETU] = evt_p[EVT_DETU];
      cond2[INT2_QCH] = evt_p[EVT_QCH];
   end
   assign trig1 = darx_trig(cond1, cond1_q, md1h, md1l);
   assign trig2 = darx_trig(cond2, cond2_q, md2h, md2l);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cond1_q <= RST_BYTE;
         cond2_q <= RST_BYTE;
         st1 <= RST_BYTE;
         st2 <= RST_BYTE;
         est <= '0;
      end else begin
         cond1_q <= cond1;
         cond2_q <= cond2;
         if (rd_en && addr == ADDR_IST1) begin
            st1 <= msk1 & trig1;
         end else begin
            st1 <= msk1 & (st1 | trig1);
         end
         if (rd_en && addr == ADDR_IST2) begin
            st2 <= msk2 & trig2;
         end else begin
            st2 <= msk2 & (st2 | trig2);
         end
         if (rd_en && addr == ADDR_RX_ERR) begin
            est <= emsk[6:0] & err_s2;
         end else begin
            est <= emsk[6:0] & (est | err_s2);
         end
      end
   end

   always_comb begin
      case (addr)
         ADDR_CTRL_GEN: next_rdata = gen;
         ADDR_CTRL_RX: next_rdata = rxc;
         ADDR_CLK_SRC: next_rdata = clks;
         ADDR_OUT_FMT: next_rdata = fmt;
         ADDR_IST1: next_rdata = st1 & msk1;
         ADDR_IST2: next_rdata = st2 & msk2;
         ADDR_IMSK1: next_rdata = msk1;
         ADDR_IMD1H: next_rdata = md1h;
         ADDR_IMD1L: next_rdata = md1l;
         ADDR_IMSK2: next_rdata = msk2;
         ADDR_IMD2H: next_rdata = md2h;
         ADDR_IMD2L: next_rdata = md2l;
         ADDR_RX_CS: next_rdata = i_rx_cs_data;
         ADDR_RX_ERR: next_rdata = {1'b0, est & emsk[6:0]};
         ADDR_ERR_MSK: next_rdata = emsk;
         ADDR_CSB_CTL: next_rdata = csb;
         ADDR_UB_CTL: next_rdata = ub;
         ADDR_RATIO: next_rdata = i_clock_ratio;
         ADDR_ID: next_rdata = ID_VAL;
         default: next_rdata = (buf_hit && clks[CLK_RUN]) ? i_buf_rdata : RST_BYTE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= RST_BYTE;
      end else if (rd_en) begin
         o_rdata <= next_rdata;
      end
   end

   assign irq_act = |(st1 & msk1) || |(st2 & msk2);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq_out <= 1'b0;
         o_irq_oe <= 1'b1;
      end else begin
         case (darx_irq_style_e'(gen[GEN_INT_LO +: 2]))
            IRQ_HIGH: begin
               o_irq_out <= irq_act;
               o_irq_oe <= 1'b1;
            end
            IRQ_LOW: begin
               o_irq_out <= !irq_act;
               o_irq_oe <= 1'b1;
            end
            IRQ_OPEN_DRAIN: begin
               o_irq_out <= 1'b0;
               o_irq_oe <= irq_act;
            end
            default: begin
               o_irq_out <= 1'b0;
               o_irq_oe <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_clk_switch <= 1'b0;
         o_justify_right <= 1'b0;
         o_msb_delay <= 1'b0;
         o_raw_mode <= 1'b0;
      end else begin
         o_clk_switch <= gen[GEN_SWCLK] && err_s2[ERR_UNLOCK];
         o_justify_right <= fmt[FMT_JUST] && fmt[FMT_OUT_PORT_MASTER_SEL];
         o_msb_delay <= fmt[FMT_DEL] && !(fmt[FMT_JUST] && fmt[FMT_OUT_PORT_MASTER_SEL]);
         o_raw_mode <= fmt[FMT_RES_LO +: 2] == RES_RAW;
      end
   end

   assign o_run = clks[CLK_RUN];
   assign o_rclk_ratio_sel = rxc[RX_RECOVERED_CLOCK_RATIO_SEL];
   assign o_input_select = rxc[RX_MUX_LO +: 3];
   assign o_out_master = fmt[FMT_OUT_PORT_MASTER_SEL];
   assign o_bclk_rate_sel = fmt[FMT_OUT_BITCLOCK_RATE_SEL];
   assign o_word_len = fmt[FMT_RES_LO +: 2];
   assign o_bclk_pol = fmt[FMT_BPOL];
   assign o_wclk_pol = fmt[FMT_WPOL];

   darx_link #(
      .SW(SW)
   ) u_link (
      .i_link_clk(i_link_clk),
      .i_rst_n(i_rst_n),
      .i_run(clks[CLK_RUN]),
      .i_mute(gen[GEN_MUTE]),
      .i_mono(rxc[RX_MMR]),
      .i_policy(rxc[RX_HOLD_LO +: 2]),
      .i_sub_valid(i_sub_valid),
      .i_sub_b(i_sub_b),
      .i_sub_err(i_sub_err),
      .i_sub_data(i_sub_data),
      .i_evt(i_evt),
      .o_evt_tgl(evt_tgl),
      .o_left(o_left),
      .o_right(o_right),
      .o_valid(o_pair_valid)
   );

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_byte_step;
      (rd_en || wr_en) && ptr[BIT_POINTER_AUTOINC];
   endsequence
   sequence s_st1_read_quiet;
      rd_en && addr == ADDR_IST1 && trig1 == RST_BYTE;
   endsequence

   AST_PTR_INC: assert property (s_byte_step |=> addr == $past(addr) + ADDR_STEP)
      else $error("Pointer did not advance.");
   AST_PTR_KEEP: assert property ((rd_en || wr_en) && !ptr[BIT_POINTER_AUTOINC] |=> $stable(ptr))
      else $error("Pointer moved without auto-increment.");
   AST_MASK_ZERO: assert property (rd_en && addr == ADDR_IST1 |=> (o_rdata & ~$past(msk1)) == RST_BYTE)
      else $error("Masked status bit read as one.");
   AST_RD_CLEAR: assert property (s_st1_read_quiet |=> st1 == RST_BYTE)
      else $error("Status not cleared by read.");
   AST_PIN_LOW: assert property ($past(gen[GEN_INT_LO +: 2]) == IRQ_LOW |-> o_irq_oe && o_irq_out == !$past(irq_act))
      else $error("Active-low pin wrong.");
   AST_PIN_OD: assert property ($past(gen[GEN_INT_LO +: 2]) == IRQ_OPEN_DRAIN |-> !o_irq_out && o_irq_oe == $past(irq_act))
      else $error("Open-drain pin wrong.");
   AST_SLIP_SET: assert property (evt_p[EVT_SLIP] && !fmt[FMT_OUT_PORT_MASTER_SEL] && msk1[INT1_OUTPUT_SLIP_FLAG] && !md1h[INT1_OUTPUT_SLIP_FLAG] && !md1l[INT1_OUTPUT_SLIP_FLAG] && !cond1_q[INT1_OUTPUT_SLIP_FLAG] |=> st1[INT1_OUTPUT_SLIP_FLAG])
      else $error("Slip not recorded.");
   AST_RECEIVER_ERROR_FLAG_LEVEL: assert property (cond1[INT1_RECEIVER_ERROR_FLAG] && msk1[INT1_RECEIVER_ERROR_FLAG] && md1h[INT1_RECEIVER_ERROR_FLAG] && !md1l[INT1_RECEIVER_ERROR_FLAG] |=> st1[INT1_RECEIVER_ERROR_FLAG] ##1 irq_act)
      else $error("Receiver error not flagged.");
   AST_CLK_SWITCH: assert property (gen[GEN_SWCLK] && err_s2[ERR_UNLOCK] |=> o_clk_switch)
      else $error("Clock switch not applied.");
   AST_JUST_MASTER: assert property (o_justify_right |-> $past(fmt[FMT_OUT_PORT_MASTER_SEL]))
      else $error("Right justify outside master mode.");
endmodule : darx_regs

// ==== core/darx_pkg.sv ====
/*
 * Constants for the audio receiver control register bank.
 * Assumes every file that needs them imports the whole package.
 */
package darx_pkg;
   localparam int SAMPLE_W = 24;
   localparam int NEVT = 4;
   localparam int EVT_SLIP = 0;
   localparam int EVT_STATUS_BUFFER_DONE_FLAG = 1;
   localparam int EVT_DETU = 2;
   localparam int EVT_QCH = 3;
   localparam logic [6:0] ADDR_CTRL_GEN = 7'h01;
   localparam logic [6:0] ADDR_CTRL_RX = 7'h02;
   localparam logic [6:0] ADDR_CLK_SRC = 7'h04;
   localparam logic [6:0] ADDR_OUT_FMT = 7'h06;
   localparam logic [6:0] ADDR_IST1 = 7'h07;
   localparam logic [6:0] ADDR_IST2 = 7'h08;
   localparam logic [6:0] ADDR_IMSK1 = 7'h09;
   localparam logic [6:0] ADDR_IMD1H = 7'h0A;
   localparam logic [6:0] ADDR_IMD1L = 7'h0B;
   localparam logic [6:0] ADDR_IMSK2 = 7'h0C;
   localparam logic [6:0] ADDR_IMD2H = 7'h0D;
   localparam logic [6:0] ADDR_IMD2L = 7'h0E;
   localparam logic [6:0] ADDR_RX_CS = 7'h0F;
   localparam logic [6:0] ADDR_RX_ERR = 7'h10;
   localparam logic [6:0] ADDR_ERR_MSK = 7'h11;
   localparam logic [6:0] ADDR_CSB_CTL = 7'h12;
   localparam logic [6:0] ADDR_UB_CTL = 7'h13;
   localparam logic [6:0] ADDR_RATIO = 7'h1E;
   localparam logic [6:0] ADDR_BUF_LO = 7'h20;
   localparam logic [6:0] ADDR_BUF_HI = 7'h37;
   localparam logic [6:0] ADDR_ID = 7'h7F;
   localparam logic [6:0] ADDR_STEP = 7'h01;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] WM_GEN = 8'hA6;
   localparam logic [7:0] WM_RX = 8'h7F;
   localparam logic [7:0] WM_CLK = 8'h40;
   localparam logic [7:0] WM_INT1 = 8'h45;
   localparam logic [7:0] WM_INT2 = 8'h0A;
   localparam logic [7:0] WM_ERR = 8'h7F;
   localparam logic [7:0] WM_CSB = 8'h3B;
   localparam logic [7:0] WM_UB = 8'h02;
   localparam int BIT_POINTER_AUTOINC = 7;
   localparam int GEN_SWCLK = 7;
   localparam int GEN_MUTE = 5;
   localparam int GEN_INT_LO = 1;
   localparam int RX_HOLD_LO = 5;
   localparam int RX_RECOVERED_CLOCK_RATIO_SEL = 4;
   localparam int RX_MMR = 3;
   localparam int RX_MUX_LO = 0;
   localparam int CLK_RUN = 6;
   localparam int FMT_OUT_PORT_MASTER_SEL = 7;
   localparam int FMT_OUT_BITCLOCK_RATE_SEL = 6;
   localparam int FMT_RES_LO = 4;
   localparam int FMT_JUST = 3;
   localparam int FMT_DEL = 2;
   localparam int FMT_BPOL = 1;
   localparam int FMT_WPOL = 0;
   localparam int INT1_OUTPUT_SLIP_FLAG = 6;
   localparam int INT1_STATUS_BUFFER_DONE_FLAG = 2;
   localparam int INT1_RECEIVER_ERROR_FLAG = 0;
   localparam int INT2_DETU = 3;
   localparam int INT2_QCH = 1;
   localparam int ERR_UNLOCK = 4;
   localparam logic [1:0] RES_RAW = 2'h3;
   localparam logic [7:0] ID_VERSION = 8'h5A;
   typedef enum logic [1:0] {IRQ_HIGH, IRQ_LOW, IRQ_OPEN_DRAIN, IRQ_RSVD} darx_irq_style_e;
   typedef enum logic [1:0] {POL_HOLD, POL_ZERO, POL_PASS, POL_RSVD} darx_policy_e;
endpackage : darx_pkg

// ==== core/darx_link.sv ====
/*
 * Link-side sample path and event toggles, clocked by the recovered clock.
 * Assumes control levels come from flip-flops in the register clock domain.
 */
`timescale 1ns/100ps
module darx_link #(
   parameter int SW = darx_pkg::SAMPLE_W
) (
   input wire logic i_link_clk,
   input wire logic i_rst_n,
   input wire logic i_run,
   input wire logic i_mute,
   input wire logic i_mono,
   input wire logic [1:0] i_policy,
   input wire logic i_sub_valid,
   input wire logic i_sub_b,
   input wire logic i_sub_err,
   input wire logic [SW-1:0] i_sub_data,
   input wire logic [darx_pkg::NEVT-1:0] i_evt,
   output logic [darx_pkg::NEVT-1:0] o_evt_tgl,
   output logic [SW-1:0] o_left,
   output logic [SW-1:0] o_right,
   output logic o_valid
);
   import darx_pkg::*;
   logic [4:0] ctl_s1;
   logic [4:0] ctl_s2;
   logic run_s;
   logic [SW-1:0] last_good;
   logic [SW-1:0] held;
   logic [SW-1:0] next_smp;

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_s1 <= '0;
         ctl_s2 <= '0;
      end else begin
         ctl_s1 <= {i_run, i_mute, i_mono, i_policy};
         ctl_s2 <= ctl_s1;
      end
   end
   assign run_s = ctl_s2[4];

   always_comb begin
      next_smp = i_sub_data;
      if (i_sub_err) begin
         case (darx_policy_e'(ctl_s2[1:0]))
            POL_ZERO: next_smp = '0;
            POL_PASS: next_smp = i_sub_data;
            default: next_smp = last_good;
         endcase
      end
      if (ctl_s2[3]) begin
         next_smp = '0;
      end
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         last_good <= '0;
      end else if (!run_s) begin
         last_good <= '0;
      end else if (i_sub_valid && !i_sub_err) begin
         last_good <= i_sub_data;
      end
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         held <= '0;
         o_left <= '0;
         o_right <= '0;
         o_valid <= 1'b0;
      end else if (!run_s) begin
         held <= '0;
         o_left <= '0;
         o_right <= '0;
         o_valid <= 1'b0;
      end else begin
         o_valid <= 1'b0;
         if (i_sub_valid) begin
            if (ctl_s2[2]) begin
               o_left <= next_smp;
               o_right <= next_smp;
               o_valid <= 1'b1;
            end else if (i_sub_b) begin
               o_left <= held;
               o_right <= next_smp;
               o_valid <= 1'b1;
            end else begin
               held <= next_smp;
            end
         end
      end
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_evt_tgl <= '0;
      end else if (run_s) begin
         o_evt_tgl <= o_evt_tgl ^ i_evt;
      end
   end

   AST_RUN_HOLD: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      !run_s |=> !o_valid) else $error("Sample output while stopped.");
   AST_MONO_DUP: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      (run_s && ctl_s2[2] && i_sub_valid) |=> (o_valid && o_left == o_right))
      else $error("Mono sample not duplicated.");
endmodule : darx_link

// ==== tb/darx_src.sv ====
/*
 * Model of the receiver front end that feeds subframes and events to the bank.
 * Assumes its tasks are called from the testbench on the link clock.
 */
`timescale 1ns/100ps
module darx_src (
   input wire logic i_link_clk,
   output logic o_sv,
   output logic o_sb,
   output logic o_se,
   output logic [23:0] o_sd,
   output logic [3:0] o_ev
);
   initial begin
      o_sv = 1'b0;
      o_sb = 1'b0;
      o_se = 1'b0;
      o_sd = 24'h000000;
      o_ev = 4'h0;
   end
   // Sends one subframe, then scrambles the data so a stale value is never seen.
   task automatic sub(input logic b, input logic e, input logic [23:0] d);
      @(posedge i_link_clk);
      o_sv <= 1'b1;
      o_sb <= b;
      o_se <= e;
      o_sd <= d;
      @(posedge i_link_clk);
      o_sv <= 1'b0;
      o_se <= ~e;
      o_sd <= ~d;
   endtask : sub
   task automatic evt(input int n);
      @(posedge i_link_clk);
      o_ev[n] <= 1'b1;
      @(posedge i_link_clk);
      o_ev <= 4'h0;
   endtask : evt
endmodule : darx_src

// ==== tb/testbench.sv ====
/*
 * Self-checking testbench of the register bank.
 * Assumes the package, the design and the front end model are compiled first.
 */
`timescale 1ns/100ps
module testbench;
   import darx_pkg::*;
   logic i_clk, i_rst_n, i_link_clk, i_map_wr, i_wr, i_rd;
   logic [7:0] i_wdata, o_rdata, i_rx_cs_data;
   logic [6:0] i_rx_err;
   logic o_irq_out, o_irq_oe, o_run, o_clk_switch, o_rclk_ratio_sel, o_out_master, o_bclk_rate_sel;
   logic o_raw_mode, o_justify_right, o_msb_delay, o_bclk_pol, o_wclk_pol, o_pair_valid;
   logic [2:0] o_input_select;
   logic [1:0] o_word_len;
   logic [23:0] o_left, o_right, cl, cr;
   logic sv, sb, se;
   logic [23:0] sd;
   logic [3:0] ev;
   int err_count = 0;
   int tests_run = 0;
   logic [6:0] ta [7] = '{7'h01, 7'h02, 7'h04, 7'h06, 7'h09, 7'h0C, 7'h11};
   logic [7:0] tm [7] = '{WM_GEN, WM_RX, WM_CLK, 8'hFF, WM_INT1, WM_INT2, WM_ERR};
   darx_regs dut (.i_clk, .i_rst_n, .i_link_clk, .i_map_wr, .i_wr, .i_rd, .i_wdata, .o_rdata,
      .i_rx_cs_data, .i_clock_ratio(~i_rx_cs_data), .i_buf_rdata(i_rx_cs_data), .i_rx_err, .i_evt(ev),
      .i_sub_valid(sv), .i_sub_b(sb), .i_sub_err(se), .i_sub_data(sd), .o_irq_out, .o_irq_oe,
      .o_run, .o_clk_switch, .o_rclk_ratio_sel, .o_input_select, .o_out_master, .o_bclk_rate_sel,
      .o_word_len, .o_raw_mode, .o_justify_right, .o_msb_delay, .o_bclk_pol, .o_wclk_pol,
      .o_left, .o_right, .o_pair_valid);
   darx_src src (.i_link_clk, .o_sv(sv), .o_sb(sb), .o_se(se), .o_sd(sd), .o_ev(ev));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #3.7;
      forever #6 i_link_clk = ~i_link_clk;
   end
   always @(posedge i_link_clk) begin
      if (o_pair_valid === 1'b1) begin
         cl <= o_left;
         cr <= o_right;
      end
   end
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk8
   task automatic chks(input logic [23:0] g, input logic [23:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: sample %h expected %h", $time, g, e);
      end
   endtask : chks
   task automatic w(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : w
   // Kind 0 loads the pointer, 1 writes, 2 reads.
   task automatic op(input int k, input logic [7:0] d);
      @(posedge i_clk);
      i_wdata <= d;
      if (k == 0) i_map_wr <= 1'b1;
      else if (k == 1) i_wr <= 1'b1;
      else i_rd <= 1'b1;
      @(posedge i_clk);
      i_map_wr <= 1'b0;
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      #1;
   endtask : op
   task automatic rdc(input logic [7:0] e);
      op(2, 8'h00);
      chk8(o_rdata, e);
   endtask : rdc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op(0, a);
      op(1, d);
   endtask : wr
   task automatic pr(input logic [23:0] a, input logic ea, input logic [23:0] b);
      w(3);
      src.sub(1'b0, ea, a);
      src.sub(1'b1, 1'b0, b);
      w(2);
   endtask : pr
   initial begin
      #200000;
      err_count++;
      final_report();
   end
   initial begin
      i_rst_n = 1'b0;
      i_map_wr = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_wdata = 8'h00;
      i_rx_cs_data = 8'hC3;
      i_rx_err = 7'h00;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      chk8({o_irq_out, o_irq_oe, o_run, o_out_master, o_word_len, o_justify_right, o_msb_delay}, 8'h40);
      op(0, 8'h81);
      for (int a = 1; a < 15; a++) rdc(8'h00);
      rdc(8'hC3);
      op(0, 8'h0F);
      rdc(8'hC3);
      rdc(8'hC3);
      op(0, 8'h9E);
      rdc(8'h3C);
      rdc(8'h00);
      rdc(8'h00);
      $display("test reset and pointer done");
      for (int i = 0; i < 7; i++) begin
         wr({1'b0, ta[i]}, 8'hFF);
         op(0, {1'b0, ta[i]});
         rdc(tm[i]);
      end
      w(2);
      chk8({o_clk_switch, o_rclk_ratio_sel, o_out_master, o_bclk_rate_sel, o_raw_mode,
         o_justify_right, o_msb_delay, o_bclk_pol}, 8'h7D);
      chk8({o_wclk_pol, o_irq_oe, o_word_len, 1'b0, o_input_select}, 8'hB7);
      wr(8'h06, 8'h08);
      w(2);
      chk8({7'h00, o_justify_right}, 8'h00);
      wr(8'h06, 8'h24);
      w(2);
      chk8({o_word_len, o_raw_mode, o_msb_delay, 4'h0}, 8'h90);
      wr(8'h0F, 8'h00);
      op(0, 8'h0F);
      rdc(8'hC3);
      wr(8'h7F, 8'h00);
      op(0, 8'h7F);
      rdc(ID_VERSION);
      for (int s = 0; s < 3; s++) begin
         wr(8'h01, 8'(s << 1));
         w(2);
         if (s < 2) chk8({6'h00, o_irq_out, o_irq_oe}, 8'(s * 2 + 1));
         else chk8({7'h00, o_irq_oe}, 8'h00);
      end
      $display("test fields done");
      for (int i = 0; i < 7; i++) wr({1'b0, ta[i]}, 8'h00);
      wr(8'h04, 8'h40);
      op(0, 8'h20);
      rdc(8'hC3);
      wr(8'h09, 8'h40);
      w(4);
      src.evt(EVT_SLIP);
      src.evt(EVT_STATUS_BUFFER_DONE_FLAG);
      w(12);
      chk8({7'h00, o_irq_out}, 8'h01);
      op(0, 8'h07);
      rdc(8'h40);
      rdc(8'h00);
      w(3);
      chk8({7'h00, o_irq_out}, 8'h00);
      wr(8'h09, 8'h04);
      src.evt(EVT_STATUS_BUFFER_DONE_FLAG);
      w(12);
      op(0, 8'h07);
      rdc(8'h04);
      wr(8'h11, 8'h10);
      wr(8'h09, 8'h01);
      wr(8'h0A, 8'h01);
      wr(8'h01, 8'h80);
      @(posedge i_clk) i_rx_err <= 7'h10;
      w(12);
      chk8({7'h00, o_clk_switch}, 8'h01);
      op(0, 8'h07);
      rdc(8'h01);
      rdc(8'h01);
      @(posedge i_clk) i_rx_err <= 7'h00;
      w(12);
      chk8({7'h00, o_clk_switch}, 8'h00);
      rdc(8'h01);
      rdc(8'h00);
      op(0, 8'h10);
      rdc(8'h10);
      rdc(8'h00);
      $display("test status done");
      pr(24'h123456, 1'b0, 24'hABCDEF);
      chks(cl, 24'h123456);
      chks(cr, 24'hABCDEF);
      pr(24'h555555, 1'b1, 24'h0F0F0F);
      chks(cl, 24'hABCDEF);
      wr(8'h02, 8'h20);
      pr(24'h654321, 1'b1, 24'h0F0F0F);
      chks(cl, 24'h000000);
      chks(cr, 24'h0F0F0F);
      wr(8'h02, 8'h40);
      pr(24'h777777, 1'b1, 24'h0F0F0F);
      chks(cl, 24'h777777);
      wr(8'h01, 8'h20);
      pr(24'h246802, 1'b0, 24'h135791);
      chks(cr, 24'h000000);
      wr(8'h01, 8'h00);
      wr(8'h02, 8'h08);
      w(3);
      src.sub(1'b0, 1'b0, 24'h111111);
      w(2);
      chks(cl, 24'h111111);
      chks(cr, 24'h111111);
      $display("test samples done");
      final_report();
   end
endmodule : testbench
